// >>> core/wasl_map.svh
/*
 * Register map, field layout and reset values of the window alert
 * status latches.
 * Assumes it is included by bare name and that the APB address
 * is a byte address with one register per aligned 32-bit word.
 */
`ifndef WASL_MAP_SVH
`define WASL_MAP_SVH

`define WASL_CHANNELS      8
`define WASL_IDX_LOW       8'h78
`define WASL_IDX_HIGH      8'h79
`define WASL_IDX_COMB      8'h7A
`define WASL_ADDR_W        12
`define WASL_BYTE_SHIFT    2
`define WASL_FLAGS_LSB     0
`define WASL_FLAGS_MSB     7
`define WASL_RST_LOW       8'h00
`define WASL_RST_HIGH      8'h00
`define WASL_RST_COMB      8'h00

`endif

// >>> core/wasl_pkg.sv
/*
 * Types shared by the window alert status latch files.
 * Assumes the map header is compiled alongside.
 */
package wasl_pkg;

  // register targeted by an APB address
  typedef enum {
    WASL_SEL_LOW,
    WASL_SEL_HIGH,
    WASL_SEL_COMB,
    WASL_SEL_NONE
  } wasl_sel_t;

  // APB slave phase
  typedef enum {
    WASL_BUS_IDLE,
    WASL_BUS_WAIT,
    WASL_BUS_DONE
  } wasl_bus_t;

endpackage

// >>> core/wasl_sticky_bank.sv
/*
 * Bank of sticky flags: set by event strobes, cleared by write-one.
 * Assumes set and clear strobes are on the same clock and that
 * en_i freezes the bank while low, except that rst_i still loads RST_VALUE.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wasl_map.svh"

module wasl_sticky_bank
  import wasl_pkg::*;
#(
  parameter int  WIDTH     = `WASL_CHANNELS,
  parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] next_q_o,
  output logic      [WIDTH-1:0] q_o
);

  // ****************************************************************
  //  per-bit next value
  // ****************************************************************
  for (genvar n = 0; n < WIDTH; n++) begin : g_bit
    always_comb begin
      // set beats clear; zero in the write mask keeps the bit
      next_q_o[n] = set_i[n] | (q_o[n] & ~clr_i[n]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_o <= RST_VALUE;
    end else if (en_i) begin
      q_o <= next_q_o;
    end
  end

endmodule

`default_nettype wire

// >>> core/wasl_top.sv
/*
 * Window alert status latches with an APB register slave.
 * Assumes the comparator strobes high_exceed_i and low_exceed_i
 * on ref_clk_i, one bit per channel, and an APB master on the
 * same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wasl_map.svh"

module wasl_top
  import wasl_pkg::*;
#(
  parameter int CHANNELS = `WASL_CHANNELS
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    clk_en_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`WASL_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  input  wire logic [CHANNELS-1:0]     high_exceed_i,
  input  wire logic [CHANNELS-1:0]     low_exceed_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  output logic      [CHANNELS-1:0]     high_alert_latch_o,
  output logic      [CHANNELS-1:0]     low_alert_latch_o,
  output logic      [CHANNELS-1:0]     combined_alert_flags_o
);

  // ****************************************************************
  //  address decode
  // ****************************************************************
  function automatic wasl_sel_t decode(input logic [`WASL_ADDR_W-1:0] a);
    logic [`WASL_ADDR_W-1:0] idx;
    idx = a >> `WASL_BYTE_SHIFT;
    if (a[`WASL_BYTE_SHIFT-1:0] != '0) begin
      decode = WASL_SEL_NONE;
    end else if (idx == `WASL_ADDR_W'(`WASL_IDX_LOW)) begin
      decode = WASL_SEL_LOW;
    end else if (idx == `WASL_ADDR_W'(`WASL_IDX_HIGH)) begin
      decode = WASL_SEL_HIGH;
    end else if (idx == `WASL_ADDR_W'(`WASL_IDX_COMB)) begin
      decode = WASL_SEL_COMB;
    end else begin
      decode = WASL_SEL_NONE;
    end
  endfunction

  wasl_sel_t            sel;
  wasl_bus_t            bus_state;
  wasl_bus_t            next_bus_state;
  logic                 next_pready;
  logic                 next_pslverr;
  logic [31:0]          next_prdata;
  logic                 wr_done;
  logic [CHANNELS-1:0]  high_clr;
  logic [CHANNELS-1:0]  low_clr;
  logic [CHANNELS-1:0]  next_high;
  logic [CHANNELS-1:0]  next_low;
  logic [CHANNELS-1:0]  next_comb;

  assign sel = decode(paddr_i);

  // ****************************************************************
  //  APB slave: one wait cycle, answer from flops
  // ****************************************************************
  always_comb begin
    next_bus_state = bus_state;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_prdata    = prdata_o;
    case (bus_state)
      WASL_BUS_IDLE: begin
        if (psel_i && penable_i) begin
          next_bus_state = WASL_BUS_DONE;
          next_pready    = 1'b1;
          next_pslverr   = (sel == WASL_SEL_NONE);
          next_prdata    = '0;
          if (!pwrite_i) begin
            case (sel)
              WASL_SEL_LOW:  next_prdata[CHANNELS-1:0] = low_alert_latch_o;
              WASL_SEL_HIGH: next_prdata[CHANNELS-1:0] = high_alert_latch_o;
              WASL_SEL_COMB: begin
                next_prdata[CHANNELS-1:0] = combined_alert_flags_o;
              end
              default:       next_prdata = '0;
            endcase
          end
        end
      end
      WASL_BUS_DONE: begin
        next_bus_state = WASL_BUS_IDLE;
      end
      default: begin
        next_bus_state = WASL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_state <= WASL_BUS_IDLE;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else if (clk_en_i) begin
      bus_state <= next_bus_state;
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o  <= next_prdata;
    end
  end

  // ****************************************************************
  //  write-one-to-clear strobes
  // ****************************************************************
  // writes land on the completing edge only
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;

  always_comb begin
    high_clr = '0;
    low_clr  = '0;
    if (wr_done && pstrb_i[0]) begin
      if (sel == WASL_SEL_HIGH) begin
        high_clr = pwdata_i[CHANNELS-1:0];
      end
      if (sel == WASL_SEL_LOW) begin
        low_clr = pwdata_i[CHANNELS-1:0];
      end
      // combined register takes no write effect
    end
  end

  // ****************************************************************
  //  sticky latches
  // ****************************************************************
  wasl_sticky_bank #(
    .WIDTH     (CHANNELS),
    .RST_VALUE (CHANNELS'(`WASL_RST_HIGH))
  ) u_high (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .en_i      (clk_en_i),
    .set_i     (high_exceed_i),
    .clr_i     (high_clr),
    .next_q_o  (next_high),
    .q_o       (high_alert_latch_o)
  );

  wasl_sticky_bank #(
    .WIDTH     (CHANNELS),
    .RST_VALUE (CHANNELS'(`WASL_RST_LOW))
  ) u_low (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .en_i      (clk_en_i),
    .set_i     (low_exceed_i),
    .clr_i     (low_clr),
    .next_q_o  (next_low),
    .q_o       (low_alert_latch_o)
  );

  // ****************************************************************
  //  combined flags, kept in step with both latches
  // ****************************************************************
  always_comb begin
    next_comb = next_high | next_low;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      combined_alert_flags_o <= CHANNELS'(`WASL_RST_COMB);
    end else if (clk_en_i) begin
      combined_alert_flags_o <= next_comb;
    end
  end

  // ****************************************************************
  //  assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) rst_i |=> (high_alert_latch_o == '0 &&
      low_alert_latch_o == '0 && combined_alert_flags_o == '0))
    else $error("latches not cleared by reset");

  AST_HIGH_SETS: assert property (
    clk_en_i |=> ((high_alert_latch_o & $past(high_exceed_i))
      == $past(high_exceed_i)))
    else $error("high exceed event not latched");

  AST_HIGH_W1C: assert property (
    (clk_en_i && high_clr != '0 && high_exceed_i == '0) |=>
      ((high_alert_latch_o & $past(high_clr)) == '0))
    else $error("write one did not clear high flag");

  AST_LOW_W1C: assert property (
    (clk_en_i && low_clr != '0 && low_exceed_i == '0) |=>
      ((low_alert_latch_o & $past(low_clr)) == '0))
    else $error("write one did not clear low flag");

  AST_COMB_IS_OR: assert property (
    combined_alert_flags_o == (high_alert_latch_o | low_alert_latch_o))
    else $error("combined flags differ from OR of latches");

  AST_COMB_WRITE_IGNORED: assert property (
    (clk_en_i && wr_done && sel == WASL_SEL_COMB &&
     high_exceed_i == '0 && low_exceed_i == '0) |=>
      $stable(combined_alert_flags_o))
    else $error("write changed combined flags");

  AST_BOTH_HOLD: assert property (
    (clk_en_i && (high_alert_latch_o & low_alert_latch_o) != '0 &&
     low_clr == '0) |=>
      ((combined_alert_flags_o & $past(low_alert_latch_o)) ==
       $past(low_alert_latch_o)))
    else $error("combined bit dropped while low flag still set");

  AST_ZERO_KEEPS: assert property (
    clk_en_i |=> ((high_alert_latch_o & $past(high_alert_latch_o & ~high_clr))
      == $past(high_alert_latch_o & ~high_clr)))
    else $error("flag lost without a clearing one");

  AST_SET_WINS: assert property (
    (clk_en_i && (low_clr & low_exceed_i) != '0) |=>
      ((low_alert_latch_o & $past(low_clr & low_exceed_i)) ==
       $past(low_clr & low_exceed_i)))
    else $error("event lost in clearing cycle");

  AST_PREADY_ONE_WAIT: assert property (
    (clk_en_i && psel_i && penable_i && !pready_o &&
     bus_state == WASL_BUS_IDLE) |=>
      pready_o ##1 (!pready_o || !$past(clk_en_i)))
    else $error("pready not a single pulse after one wait");

  COV_HIGH_CLEAR: cover property (
    high_alert_latch_o[0] ##[1:20] !high_alert_latch_o[0]);
  COV_BOTH_THEN_CLEAR: cover property (
    (high_alert_latch_o[3] && low_alert_latch_o[3]) ##[1:40]
      !combined_alert_flags_o[3]);
  COV_SET_CLEAR_SAME: cover property (
    clk_en_i && (high_clr & high_exceed_i) != '0);
  COV_UNMAPPED: cover property (pready_o && pslverr_o);

endmodule

`default_nettype wire

// >>> verification/wasl_top_tb_top.sv
/*
 * Self-checking bench for the window alert status latches.
 * Assumes the APB slave answers with a bounded number of wait states
 * and that exceed strobes are sampled on every enabled clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wasl_map.svh"

module wasl_top_tb_top;
  localparam logic [11:0] A_LO = {2'h0, `WASL_IDX_LOW, 2'h0};
  localparam logic [11:0] A_HI = {2'h0, `WASL_IDX_HIGH, 2'h0};
  localparam logic [11:0] A_CB = {2'h0, `WASL_IDX_COMB, 2'h0};
  logic        ref_clk_i, rst_i, clk_en_i, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0]  pstrb;
  logic [7:0]  hx, lx, hi_o, lo_o, cb_o, eh, el;
  logic        pready, pslverr, er;
  int          err_count, n_compared, cyc, i;
  logic [11:0] bad [3] = '{12'h1EC, 12'h1E5, 12'h000};

  wasl_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .high_exceed_i(hx),
    .low_exceed_i(lx), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .high_alert_latch_o(hi_o),
    .low_alert_latch_o(lo_o), .combined_alert_flags_o(cb_o));

  //****************************************************************
  // helpers
  //****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'h0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [7:0] w1c(input logic [7:0] q,
                                     input logic [7:0] d,
                                     input logic       s);
    return s ? (q & ~d) : q;
  endfunction

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk_i);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      err_count++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(a, 1'h1, d, s);
    chk("write error", 32'h0, {31'h0, er});
    if (a == A_HI) eh = w1c(eh, d[7:0], s[0]);
    if (a == A_LO) el = w1c(el, d[7:0], s[0]);
  endtask

  task automatic ev(input logic [7:0] h, input logic [7:0] l);
    @(posedge ref_clk_i);
    hx <= h;
    lx <= l;
    @(posedge ref_clk_i);
    hx <= 8'h0;
    lx <= 8'h0;
    eh = eh | h;
    el = el | l;
  endtask

  task automatic check_all();
    apb(A_LO, 1'h0, 32'h0, 4'h0);
    chk("low reg", {24'h0, el}, rd);
    apb(A_HI, 1'h0, 32'h0, 4'h0);
    chk("high reg", {24'h0, eh}, rd);
    apb(A_CB, 1'h0, 32'h0, 4'h0);
    chk("comb reg", {24'h0, eh | el}, rd);
    @(negedge ref_clk_i);
    chk("high out", {24'h0, eh}, {24'h0, hi_o});
    chk("low out", {24'h0, el}, {24'h0, lo_o});
    chk("comb out", {24'h0, eh | el}, {24'h0, cb_o});
  endtask

  //****************************************************************
  // clock, timeout and main sequence
  //****************************************************************
  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, hx, lx} = '0;
    {eh, el, err_count, n_compared, cyc} = '0;
    rst_i = 1'h1;
    clk_en_i = 1'h1;
    r = 32'hC0991ECE;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    check_all();
    for (i = 0; i < 40; i++) begin
      r = lfsr(r);
      ev(r[7:0] & r[23:16], r[15:8] & r[31:24]);
      r = lfsr(r);
      wr(r[0] ? A_HI : A_LO, r, {3'h0, r[1] | r[2]});
      check_all();
    end
    // both sources on one channel
    wr(A_HI, 32'hFF, 4'hF);
    wr(A_LO, 32'hFF, 4'hF);
    ev(8'h08, 8'h08);
    wr(A_HI, 32'h08, 4'hF);
    check_all();
    chk("comb bit 3", 32'h1, {31'h0, cb_o[3]});
    wr(A_LO, 32'h08, 4'hF);
    check_all();
    // exceed held across a clearing write, both latches
    ev(8'hFF, 8'hFF);
    @(posedge ref_clk_i);
    hx <= 8'h81;
    lx <= 8'h18;
    wr(A_HI, 32'hFF, 4'hF);
    wr(A_LO, 32'hFF, 4'hF);
    eh = eh | 8'h81;
    el = el | 8'h18;
    hx <= 8'h0;
    lx <= 8'h0;
    check_all();
    // combined register ignores writes
    ev(8'h00, 8'h24);
    wr(A_CB, 32'hFF, 4'hF);
    check_all();
    // unmapped and misaligned addresses
    foreach (bad[k]) begin
      apb(bad[k], 1'h0, 32'h0, 4'h0);
      chk("bad read", 32'h1, {31'h0, er});
      chk("bad data", 32'h0, rd);
      apb(bad[k], 1'h1, 32'hFF, 4'hF);
      chk("bad write", 32'h1, {31'h0, er});
    end
    check_all();
    // frozen clock enable ignores strobes
    wr(A_HI, 32'hFF, 4'hF);
    @(posedge ref_clk_i);
    clk_en_i <= 1'h0;
    hx <= 8'h40;
    @(posedge ref_clk_i);
    hx <= 8'h0;
    clk_en_i <= 1'h1;
    check_all();
    // reset in mid-run, clock enable low meanwhile
    ev(8'h3C, 8'hC3);
    @(posedge ref_clk_i);
    rst_i <= 1'h1;
    clk_en_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    clk_en_i <= 1'h1;
    eh = 8'h0;
    el = 8'h0;
    check_all();
    finish_test();
  end
endmodule

`default_nettype wire
